// [shared/fba_map.svh]
// register offsets, field positions, reset values and sizes for buffer admission
`ifndef FBA_MAP_SVH
`define FBA_MAP_SVH

`define FBA_ADDR_W 4
`define FBA_CNT_W 10
`define FBA_NUM_SRC 6
`define FBA_NUM_CLS 3

// register offsets
`define FBA_REG_FAST_RSV 4'h0
`define FBA_REG_HOST_RSV 4'h1
`define FBA_REG_UPLINK_RSV 4'h2
`define FBA_REG_SHARED 4'h3
`define FBA_REG_LOW_CLS 4'h4
`define FBA_REG_MID_CLS 4'h5
`define FBA_REG_TOP_CLS 4'h6
`define FBA_REG_CTRL 4'h7
`define FBA_REG_MC_THR 4'h8
`define FBA_REG_STATUS 4'h9
`define FBA_REG_SHARED_USE 4'hA
`define FBA_REG_MC_COUNT 4'hB

// control register fields
`define FBA_CTRL_FC_LSB 0
`define FBA_CTRL_FC_W 6
`define FBA_CTRL_PROB_LSB 8
`define FBA_CTRL_PROB_W 8
`define FBA_CTRL_LOWTH_LSB 16
`define FBA_CTRL_XOFF_LSB 24
`define FBA_CTRL_FIELD_W 8

// reset values
`define FBA_RST_FAST_RSV 10'h010
`define FBA_RST_HOST_RSV 10'h010
`define FBA_RST_UPLINK_RSV 10'h020
`define FBA_RST_SHARED 10'h100
`define FBA_RST_CLS 10'h020
`define FBA_RST_CTRL 32'h0C04_4000
`define FBA_RST_MC_THR 10'h040

// source port numbering: 0..3 fast, 4 uplink, 5 host (port number 8)
`define FBA_SRC_UPLINK 3'h4
`define FBA_SRC_HOST 3'h5
`define FBA_LFSR_SEED 8'hA5

`endif

// [shared/fba_pkg.sv]
// types for the buffer admission block
package fba_pkg;
	// region a slot was charged to
	typedef enum logic [2:0] {
		FBA_REG_TEMP,
		FBA_REG_CLASS,
		FBA_REG_POOL,
		FBA_REG_PORT,
		FBA_REG_NONE
	} fba_region_e;

	// transmit queue of a merged port
	typedef enum logic [1:0] {
		FBA_Q_BEST,
		FBA_Q_AF1,
		FBA_Q_AF2,
		FBA_Q_TOP
	} fba_queue_e;
endpackage

// [verilog/fba_sched.sv]
// strict priority queue selector, best effort served only when others idle
`timescale 1ns/1ps
`include "fba_map.svh"

module fba_sched (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// queue state
	input wire logic [3:0] q_ready_i,
	// selection
	output logic [1:0] q_sel_o,
	output logic q_valid_o
);
	logic [1:0] sel;
	logic valid;
	wire logic [1:0] next_sel = q_ready_i[3] ? 2'h3 : q_ready_i[2] ? 2'h2 : q_ready_i[1] ? 2'h1 : 2'h0;
	// best effort only when every higher queue is empty
	wire logic next_valid = |q_ready_i;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sel <= 2'h0;
			valid <= 1'b0;
		end else begin
			sel <= next_sel;
			valid <= next_valid;
		end
	end

	assign q_sel_o = sel;
	assign q_valid_o = valid;

	property p_best_only_idle;
		@(posedge clk_i) disable iff (reset_i)
		q_valid_o && q_sel_o == 2'h0 |-> $past(q_ready_i[3:1]) == 3'h0;
	endproperty
	a_best_only_idle: assert property (p_best_only_idle) else $error("best effort served while others busy");
endmodule

// [verilog/fba_admit.sv]
// frame buffer admission, region accounting and pause requests
`timescale 1ns/1ps
`include "fba_map.svh"

module fba_admit (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// register port
	input wire logic [`FBA_ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// frame arrival from receive macs
	input wire logic arrive_i,
	input wire logic [2:0] arrive_src_i,
	// switching decision from classifier
	input wire logic decide_i,
	input wire logic [2:0] decide_src_i,
	input wire logic [2:0] decide_prio_i,
	input wire logic decide_mcast_i,
	input wire logic queue_congest_i,
	// release from output queue manager
	input wire logic release_i,
	input wire logic [2:0] release_src_i,
	input wire fba_pkg::fba_region_e release_region_i,
	input wire logic [2:0] release_prio_i,
	input wire logic release_mcast_i,
	// transmit queue state
	input wire logic [3:0] q_ready_i,
	// decision results
	output logic result_valid_o,
	output logic result_drop_o,
	output fba_pkg::fba_region_e result_region_o,
	output fba_pkg::fba_queue_e result_queue_o,
	output logic [2:0] result_prio_o,
	output logic result_wred_o,
	// pause requests and scheduler
	output logic [`FBA_NUM_SRC-1:0] pause_o,
	output logic mc_pause_o,
	output logic [1:0] q_sel_o,
	output logic q_valid_o
);
	//////////////////////////////////////////////////////////////////////
	// registers
	logic [`FBA_CNT_W-1:0] fast_port_reserve_size;
	logic [`FBA_CNT_W-1:0] host_port_reserve_size;
	logic [`FBA_CNT_W-1:0] uplink_port_reserve_size;
	logic [`FBA_CNT_W-1:0] shared_pool_size;
	logic [`FBA_CNT_W-1:0] cls_size [`FBA_NUM_CLS];
	logic [31:0] ctrl;
	logic [`FBA_CNT_W-1:0] mc_thr;

	// occupancy counters
	logic [`FBA_CNT_W-1:0] temp_use;
	logic [`FBA_CNT_W-1:0] pool_use;
	logic [`FBA_CNT_W-1:0] mc_count;
	logic [`FBA_CNT_W-1:0] prio_use [8];
	logic [`FBA_CNT_W-1:0] port_use [`FBA_NUM_SRC];
	logic [`FBA_NUM_SRC-1:0] paused;
	logic mc_paused;
	logic [7:0] lfsr;

	function automatic logic [1:0] cls_of(input logic [2:0] prio);
		cls_of = prio[2:1] - 2'h1;
	endfunction

	// sizes passed in: a wire only wakes up on its own operands
	function automatic logic [`FBA_CNT_W-1:0] rsv_of(input logic [2:0] src, input logic [`FBA_CNT_W-1:0] host,
		input logic [`FBA_CNT_W-1:0] upl, input logic [`FBA_CNT_W-1:0] fast);
		if (src == `FBA_SRC_HOST) rsv_of = host;
		else if (src == `FBA_SRC_UPLINK) rsv_of = upl;
		else rsv_of = fast;
	endfunction

	// class occupancy is the sum of a priority pair
	function automatic logic [`FBA_CNT_W-1:0] cls_use(input logic [`FBA_CNT_W-1:0] a, input logic [`FBA_CNT_W-1:0] b);
		cls_use = a + b;
	endfunction

	//////////////////////////////////////////////////////////////////////
	// control fields
	wire logic [`FBA_NUM_SRC-1:0] fc_en = ctrl[`FBA_CTRL_FC_LSB +: `FBA_CTRL_FC_W];
	wire logic [7:0] drop_prob = ctrl[`FBA_CTRL_PROB_LSB +: `FBA_CTRL_PROB_W];
	wire logic [`FBA_CNT_W-1:0] low_thr = {2'h0, ctrl[`FBA_CTRL_LOWTH_LSB +: `FBA_CTRL_FIELD_W]};
	wire logic [`FBA_CNT_W-1:0] xoff_thr = {2'h0, ctrl[`FBA_CTRL_XOFF_LSB +: `FBA_CTRL_FIELD_W]};

	//////////////////////////////////////////////////////////////////////
	// admission decode
	wire logic src_fc = fc_en[decide_src_i];
	// flow controlled sources lose prioritisation
	wire logic [2:0] eff_prio = src_fc ? 3'h0 : decide_prio_i;
	wire logic upper = eff_prio[2] | eff_prio[1];
	wire logic [1:0] dc = cls_of(eff_prio);
	wire logic [1:0] pair = dc + 2'h1;
	wire logic cls_room = upper && (cls_use(prio_use[{pair, 1'b0}], prio_use[{pair, 1'b1}]) < cls_size[dc]);
	wire logic pool_room = pool_use < shared_pool_size;
	wire logic [`FBA_CNT_W-1:0] src_rsv = rsv_of(decide_src_i, host_port_reserve_size, uplink_port_reserve_size,
		fast_port_reserve_size);
	wire logic [`FBA_CNT_W-1:0] src_use = port_use[decide_src_i];
	wire logic port_room = src_use < src_rsv;
	wire logic [`FBA_CNT_W-1:0] src_left = src_rsv - src_use;
	// class section, else shared pool, else source reserve
	wire fba_pkg::fba_region_e pick = cls_room ? fba_pkg::FBA_REG_CLASS : pool_room ? fba_pkg::FBA_REG_POOL :
		port_room ? fba_pkg::FBA_REG_PORT : fba_pkg::FBA_REG_NONE;
	// pairs of priorities merge onto four queues
	wire fba_pkg::fba_queue_e queue = fba_pkg::fba_queue_e'(eff_prio[2:1]);
	wire logic best = queue == fba_pkg::FBA_Q_BEST;
	// scarcity drops only; no bandwidth or delay policing here
	wire logic no_space = pick == fba_pkg::FBA_REG_NONE;
	wire logic rand_hit = lfsr < drop_prob;
	wire logic congest_pool = queue_congest_i && !pool_room && rand_hit;
	wire logic congest_low = queue_congest_i && (src_left < low_thr);
	wire logic be_drop = best && !src_fc && (no_space || congest_pool || congest_low);
	// a frame with no space at all is never stored
	wire logic drop = be_drop || no_space;

	//////////////////////////////////////////////////////////////////////
	// register port
	wire logic wr_fast = reg_write_i && reg_addr_i == `FBA_REG_FAST_RSV;
	wire logic wr_host = reg_write_i && reg_addr_i == `FBA_REG_HOST_RSV;
	wire logic wr_upl = reg_write_i && reg_addr_i == `FBA_REG_UPLINK_RSV;
	wire logic wr_shared = reg_write_i && reg_addr_i == `FBA_REG_SHARED;
	wire logic wr_ctrl = reg_write_i && reg_addr_i == `FBA_REG_CTRL;
	wire logic wr_mc = reg_write_i && reg_addr_i == `FBA_REG_MC_THR;
	wire logic [`FBA_CNT_W-1:0] wval = reg_wdata_i[`FBA_CNT_W-1:0];
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0;
		unique case (reg_addr_i)
			`FBA_REG_FAST_RSV: rd_mux = {22'h0, fast_port_reserve_size};
			`FBA_REG_HOST_RSV: rd_mux = {22'h0, host_port_reserve_size};
			`FBA_REG_UPLINK_RSV: rd_mux = {22'h0, uplink_port_reserve_size};
			`FBA_REG_SHARED: rd_mux = {22'h0, shared_pool_size};
			`FBA_REG_LOW_CLS: rd_mux = {22'h0, cls_size[0]};
			`FBA_REG_MID_CLS: rd_mux = {22'h0, cls_size[1]};
			`FBA_REG_TOP_CLS: rd_mux = {22'h0, cls_size[2]};
			`FBA_REG_CTRL: rd_mux = ctrl;
			`FBA_REG_MC_THR: rd_mux = {22'h0, mc_thr};
			`FBA_REG_STATUS: rd_mux = {15'h0, mc_paused, 10'h0, paused};
			`FBA_REG_SHARED_USE: rd_mux = {22'h0, pool_use};
			`FBA_REG_MC_COUNT: rd_mux = {22'h0, mc_count};
			default: rd_mux = 32'h0;
		endcase
	end

	// four region sizes, control and multicast threshold
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fast_port_reserve_size <= `FBA_RST_FAST_RSV;
			host_port_reserve_size <= `FBA_RST_HOST_RSV;
			uplink_port_reserve_size <= `FBA_RST_UPLINK_RSV;
			shared_pool_size <= `FBA_RST_SHARED;
			ctrl <= `FBA_RST_CTRL;
			mc_thr <= `FBA_RST_MC_THR;
			reg_rdata_o <= 32'h0;
		end else begin
			if (wr_fast) fast_port_reserve_size <= wval;
			if (wr_host) host_port_reserve_size <= wval;
			if (wr_upl) uplink_port_reserve_size <= wval;
			if (wr_shared) shared_pool_size <= wval;
			if (wr_ctrl) ctrl <= reg_wdata_i;
			if (wr_mc) mc_thr <= wval;
			reg_rdata_o <= reg_read_i ? rd_mux : 32'h0;
		end
	end

	for (genvar c = 0; c < `FBA_NUM_CLS; c++) begin : g_cls
		wire logic wr_c = reg_write_i && reg_addr_i == (`FBA_REG_LOW_CLS + 4'(c));
		always_ff @(posedge clk_i) begin
			if (reset_i) cls_size[c] <= `FBA_RST_CLS;
			else if (wr_c) cls_size[c] <= wval;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// accounting
	wire logic stored = decide_i && !drop;
	wire logic rel_pool = release_i && release_region_i == fba_pkg::FBA_REG_POOL;

	// arrival charged to temp; decision moves it out
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			temp_use <= '0;
			pool_use <= '0;
			mc_count <= '0;
			lfsr <= `FBA_LFSR_SEED;
		end else begin
			temp_use <= temp_use + `FBA_CNT_W'(arrive_i) - `FBA_CNT_W'(decide_i);
			pool_use <= pool_use + `FBA_CNT_W'(stored && pick == fba_pkg::FBA_REG_POOL)
				- `FBA_CNT_W'(rel_pool);
			mc_count <= mc_count + `FBA_CNT_W'(stored && decide_mcast_i)
				- `FBA_CNT_W'(release_i && release_mcast_i);
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	// eight priorities counted separately
	for (genvar p = 0; p < 8; p++) begin : g_prio
		wire logic inc = stored && pick == fba_pkg::FBA_REG_CLASS && eff_prio == 3'(p);
		wire logic dec = release_i && release_region_i == fba_pkg::FBA_REG_CLASS && release_prio_i == 3'(p);
		always_ff @(posedge clk_i) begin
			if (reset_i) prio_use[p] <= '0;
			else prio_use[p] <= prio_use[p] + `FBA_CNT_W'(inc) - `FBA_CNT_W'(dec);
		end
	end

	// per source reservation use and pause state
	for (genvar s = 0; s < `FBA_NUM_SRC; s++) begin : g_src
		wire logic inc = stored && pick == fba_pkg::FBA_REG_PORT && decide_src_i == 3'(s);
		wire logic dec = release_i && release_region_i == fba_pkg::FBA_REG_PORT && release_src_i == 3'(s);
		wire logic [`FBA_CNT_W-1:0] next_use = port_use[s] + `FBA_CNT_W'(inc) - `FBA_CNT_W'(dec);
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				port_use[s] <= '0;
				paused[s] <= 1'b0;
			end else begin
				port_use[s] <= next_use;
				if (fc_en[s] && next_use >= xoff_thr && xoff_thr != '0) paused[s] <= 1'b1;
				else if (next_use == '0) paused[s] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) mc_paused <= 1'b0;
		else mc_paused <= mc_count > mc_thr;
	end

	//////////////////////////////////////////////////////////////////////
	// decision outputs
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			result_valid_o <= 1'b0;
			result_drop_o <= 1'b0;
			result_region_o <= fba_pkg::FBA_REG_NONE;
			result_queue_o <= fba_pkg::FBA_Q_BEST;
			result_prio_o <= 3'h0;
			result_wred_o <= 1'b0;
		end else begin
			result_valid_o <= decide_i;
			result_drop_o <= decide_i && drop;
			result_region_o <= drop ? fba_pkg::FBA_REG_NONE : pick;
			result_queue_o <= queue;
			result_prio_o <= eff_prio;
			// wred applies to non best effort queues only; flow controlled frames go best effort and never get it
			result_wred_o <= decide_i && !best;
		end
	end

	assign pause_o = paused;
	assign mc_pause_o = mc_paused;

	fba_sched u_sched (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.q_ready_i(q_ready_i),
		.q_sel_o(q_sel_o),
		.q_valid_o(q_valid_o)
	);

	//////////////////////////////////////////////////////////////////////
	// checks
	property p_resume_empty;
		@(posedge clk_i) disable iff (reset_i)
		$fell(pause_o[1]) |-> port_use[1] == '0;
	endproperty
	a_resume_empty: assert property (p_resume_empty) else $error("resume with slots held");

	property p_mc_pause;
		@(posedge clk_i) disable iff (reset_i)
		(mc_count > mc_thr) |=> mc_pause_o;
	endproperty
	a_mc_pause: assert property (p_mc_pause) else $error("multicast pause missing");

	property p_fc_no_drop;
		@(posedge clk_i) disable iff (reset_i)
		decide_i && src_fc && !no_space |=> !result_drop_o;
	endproperty
	a_fc_no_drop: assert property (p_fc_no_drop) else $error("flow controlled frame dropped");

	property p_low_drop;
		@(posedge clk_i) disable iff (reset_i)
		decide_i && best && !src_fc && congest_low |=> result_valid_o && result_drop_o;
	endproperty
	a_low_drop: assert property (p_low_drop) else $error("low reserve drop missed");

	property p_low_prio_no_class;
		@(posedge clk_i) disable iff (reset_i)
		decide_i && !upper |=> result_region_o != fba_pkg::FBA_REG_CLASS;
	endproperty
	a_low_prio_no_class: assert property (p_low_prio_no_class) else $error("low priority in class region");

	property p_fc_best;
		@(posedge clk_i) disable iff (reset_i)
		decide_i && src_fc |=> result_queue_o == fba_pkg::FBA_Q_BEST;
	endproperty
	a_fc_best: assert property (p_fc_best) else $error("flow controlled frame not best effort");

	property p_wred_high;
		@(posedge clk_i) disable iff (reset_i)
		decide_i && eff_prio[2] |=> result_wred_o;
	endproperty
	a_wred_high: assert property (p_wred_high) else $error("high priority not under wred");

	property p_temp_track;
		@(posedge clk_i) disable iff (reset_i)
		arrive_i && !decide_i |=> temp_use == $past(temp_use) + 10'h001;
	endproperty
	a_temp_track: assert property (p_temp_track) else $error("temporary region not charged");
endmodule

// [dv/fba_far_model.sv]
// far side model: classifier pairing and output queue releases
`timescale 1ns/1ps
module fba_far_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// traffic seen at the block
	input wire logic decide_i,
	input wire logic [2:0] decide_src_i,
	input wire logic decide_mcast_i,
	input wire logic result_valid_i,
	input wire logic result_drop_i,
	input wire fba_pkg::fba_region_e result_region_i,
	input wire logic [2:0] result_prio_i,
	input wire logic hold_i,
	// releases toward the block
	output logic release_o,
	output logic [2:0] release_src_o,
	output fba_pkg::fba_region_e release_region_o,
	output logic [2:0] release_prio_o,
	output logic release_mcast_o
);
	logic [3:0] pend_q[$];
	logic [9:0] rel_q[$];
	logic [9:0] e;
	int gap = 0;
	////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		release_o <= 1'b0;
		// stale source and priority fields scrambled so nothing leans on old values
		release_src_o <= ~release_src_o;
		release_prio_o <= ~release_prio_o;
		if (decide_i)
			pend_q.push_back({decide_src_i, decide_mcast_i});
		if (result_valid_i) begin
			e[3:0] = pend_q.pop_front();
			if (!result_drop_i)
				rel_q.push_back({e[3:1], result_region_i, result_prio_i, e[0]});
		end
		if (gap > 0)
			gap--;
		else if (!hold_i && !reset_i && rel_q.size() > 0) begin
			e = rel_q.pop_front();
			release_o <= 1'b1;
			release_src_o <= e[9:7];
			release_region_o <= fba_pkg::fba_region_e'(e[6:4]);
			release_prio_o <= e[3:1];
			release_mcast_o <= e[0];
			// spacing varies so releases come both prompt and slow
			gap = 4 + $urandom_range(3);
		end
		if (reset_i) begin
			pend_q.delete();
			rel_q.delete();
			release_src_o <= 3'h0;
			release_prio_o <= 3'h0;
			release_region_o <= fba_pkg::FBA_REG_NONE;
			release_mcast_o <= 1'b0;
		end
	end
endmodule

// [dv/fba_admit_tb.sv]
// self-checking bench for buffer admission and pause logic
`timescale 1ns/1ps
`include "fba_map.svh"
module fba_admit_tb;
	localparam fba_pkg::fba_region_e rg_cls = fba_pkg::FBA_REG_CLASS;
	localparam fba_pkg::fba_region_e rg_pool = fba_pkg::FBA_REG_POOL;
	localparam fba_pkg::fba_region_e rg_port = fba_pkg::FBA_REG_PORT;
	localparam fba_pkg::fba_region_e rg_none = fba_pkg::FBA_REG_NONE;
	logic clk_i;
	logic reset_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic arrive_i = 1'b0;
	logic [2:0] arrive_src_i = 3'h0;
	logic decide_i = 1'b0;
	logic [2:0] decide_src_i = 3'h0;
	logic [2:0] decide_prio_i = 3'h0;
	logic decide_mcast_i = 1'b0;
	logic queue_congest_i = 1'b0;
	logic release_i;
	logic [2:0] release_src_i;
	fba_pkg::fba_region_e release_region_i;
	logic [2:0] release_prio_i;
	logic release_mcast_i;
	logic [3:0] q_ready_i = 4'h0;
	logic result_valid_o;
	logic result_drop_o;
	fba_pkg::fba_region_e result_region_o;
	fba_pkg::fba_queue_e result_queue_o;
	logic [2:0] result_prio_o;
	logic result_wred_o;
	logic [5:0] pause_o;
	logic mc_pause_o;
	logic [1:0] q_sel_o;
	logic q_valid_o;
	logic hold = 1'b0;
	logic rd_d = 1'b0;
	logic [31:0] rd_q[$];
	logic [9:0] exp_q[$];
	int cnt1 = 0;
	int miscompares = 0;
	int check_count = 0;
	logic [31:0] rst_v [13] = '{32'h10, 32'h10, 32'h20, 32'h100, 32'h20, 32'h20, 32'h20,
		32'h0C04_4000, 32'h40, 32'h0, 32'h0, 32'h0, 32'h0};
	////////////////////////////////////////////////////////////////
	fba_admit uut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .arrive_i(arrive_i),
		.arrive_src_i(arrive_src_i), .decide_i(decide_i), .decide_src_i(decide_src_i),
		.decide_prio_i(decide_prio_i), .decide_mcast_i(decide_mcast_i), .queue_congest_i(queue_congest_i),
		.release_i(release_i), .release_src_i(release_src_i), .release_region_i(release_region_i),
		.release_prio_i(release_prio_i), .release_mcast_i(release_mcast_i), .q_ready_i(q_ready_i),
		.result_valid_o(result_valid_o), .result_drop_o(result_drop_o), .result_region_o(result_region_o),
		.result_queue_o(result_queue_o), .result_prio_o(result_prio_o), .result_wred_o(result_wred_o),
		.pause_o(pause_o), .mc_pause_o(mc_pause_o), .q_sel_o(q_sel_o), .q_valid_o(q_valid_o));
	fba_far_model far (.clk_i(clk_i), .reset_i(reset_i), .decide_i(decide_i), .decide_src_i(decide_src_i),
		.decide_mcast_i(decide_mcast_i), .result_valid_i(result_valid_o), .result_drop_i(result_drop_o),
		.result_region_i(result_region_o), .result_prio_i(result_prio_o), .hold_i(hold),
		.release_o(release_i), .release_src_o(release_src_i), .release_region_o(release_region_i),
		.release_prio_o(release_prio_i), .release_mcast_o(release_mcast_i));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		check_count++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %0t %s got %h expected %h", $time, m, g, x);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] x);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		rd_q.push_back(x);
		@(posedge clk_i);
		reg_read_i <= 1'b0;
	endtask
	// flow controlled sources are expected at priority zero
	task automatic frame(input logic [2:0] s, input logic [2:0] p, input logic m, input logic c,
		input fba_pkg::fba_region_e r, input logic fc);
		logic [2:0] ep;
		ep = fc ? 3'h0 : p;
		@(posedge clk_i);
		arrive_i <= 1'b1;
		arrive_src_i <= s;
		@(posedge clk_i);
		arrive_i <= 1'b0;
		decide_i <= 1'b1;
		decide_src_i <= s;
		decide_prio_i <= p;
		decide_mcast_i <= m;
		queue_congest_i <= c;
		exp_q.push_back({r == rg_none, r, ep[2:1], ep, ep[2:1] != 2'h0});
		if (s == 3'h1 && r == rg_port)
			cnt1++;
		@(posedge clk_i);
		decide_i <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		rd_d <= reg_read_i;
		if (rd_d)
			chk(reg_rdata_o, rd_q.pop_front(), "read data");
		if (result_valid_o)
			chk({result_drop_o, result_region_o, result_queue_o, result_prio_o, result_wred_o},
				exp_q.pop_front(), "decision");
		if (release_i && release_src_i == 3'h1 && release_region_i == rg_port)
			cnt1--;
	end
	initial begin
		#(8 * 20000);
		miscompares++;
		results();
	end
	initial begin
		void'($urandom(32'h626A));
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 13; i++) rd(i[3:0], rst_v[i]);
		wr(`FBA_REG_STATUS, 32'hFFFF_FFFF);
		rd(`FBA_REG_STATUS, 32'h0);
		wr(`FBA_REG_SHARED, 32'hFFFF_FC05);
		rd(`FBA_REG_SHARED, 32'h5);
		wr(`FBA_REG_SHARED, 32'h100);
		for (int p = 0; p < 8; p++) frame(3'($urandom_range(3)), p[2:0], 1'b0, 1'b0, p > 1 ? rg_cls : rg_pool, 1'b0);
		// xoff 5, low mark 4, drop chance zero, source 1 flow controlled
		wr(`FBA_REG_CTRL, 32'h0504_0002);
		frame(3'h1, 3'h7, 1'b0, 1'b0, rg_pool, 1'b1);
		repeat (60) @(posedge clk_i);
		hold <= 1'b1;
		wr(`FBA_REG_SHARED, 32'h0);
		wr(`FBA_REG_FAST_RSV, 32'h6);
		for (int k = 0; k < 8; k++) frame(3'h0, 3'h0, 1'b0, k < 4, (k == 3 || k == 7) ? rg_none : rg_port, 1'b0);
		for (int k = 0; k < 8; k++) frame(3'h1, 3'h5, 1'b0, 1'b1, k < 6 ? rg_port : rg_none, 1'b1);
		@(negedge clk_i);
		chk({26'h0, pause_o}, 32'h2, "pause level");
		rd(`FBA_REG_STATUS, 32'h2);
		hold <= 1'b0;
		for (int i = 0; i < 300 && pause_o[1] !== 1'b0; i++) @(negedge clk_i);
		chk(32'(cnt1), 32'h0, "resume before all released");
		chk({26'h0, pause_o}, 32'h0, "pause cleared");
		// multicast count must pass the threshold, not just reach it
		wr(`FBA_REG_MC_THR, 32'h1);
		hold <= 1'b1;
		frame(3'h2, 3'h6, 1'b1, 1'b0, rg_cls, 1'b0);
		repeat (3) @(negedge clk_i);
		chk(mc_pause_o, 32'h0, "mc pause at threshold");
		frame(3'h2, 3'h6, 1'b1, 1'b0, rg_cls, 1'b0);
		repeat (3) @(negedge clk_i);
		chk(mc_pause_o, 32'h1, "mc pause above threshold");
		rd(`FBA_REG_MC_COUNT, 32'h2);
		hold <= 1'b0;
		repeat (60) @(negedge clk_i);
		chk(mc_pause_o, 32'h0, "mc pause released");
		rd(`FBA_REG_MC_COUNT, 32'h0);
		rd(`FBA_REG_SHARED_USE, 32'h0);
		for (int v = 0; v < 16; v++) begin
			@(posedge clk_i);
			q_ready_i <= v[3:0];
			repeat (2) @(negedge clk_i);
			chk({q_valid_o, v != 0 ? q_sel_o : 2'h0}, {v != 0, v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0}, "queue pick");
		end
		repeat (4) @(posedge clk_i);
		results();
	end
endmodule
